/* File: pafs_fill.sv */
/*
 * Block-fill sequencer: AHB-Lite register slave, window preclip,
 * row shape and alignment classing, and a state-exact walk of setup
 * and transfer that strobes one 16-bit word write per word.
 * Assumes hclk is the machine state clock and int_req is asynchronous.
 */
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - fill time is setup states plus transfer states
// - clipping and pointer adjust end before the first word write
// - setup 4 linear; XY 6 unclipped, 9 when array fits
// - XY setup 16 start adjust, 12 dimension adjust, 20 both
// - corner adjust settings never change fill setup cost
// - three more setup states with instruction cache off
// - working L rows by M pixels come from clipped pointer and extent
// - words per row from pointer, clipped X and pixel size; short/medium/long
// - row is lead word, N-2 centre words, trail word; classes A-D
// - centre words are whole 16-bit writes; only edges partial
// - one-word row costs per class A, B, C/D formulas
// - two-word row costs per class A, B/C, D formulas
// - long row costs per class A, B, C, D formulas
// - one word per step, increasing X then increasing Y
// - odd pitch: classes may vary, C average, D worst; code keeps the first row's class for every row
// - masking, transparency, insertion cost 2 states per word minimum
// - plain G is 2, 4, 5, 6 by op group
// - read-before-write G is 4, 6, 7, 8 by op group
// - masking or transparency drops 2 per row B/C, 4 per row D
// - suspend at word or row boundary, set flag, within 20 states
module pafs_fill (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic int_req,
   output pafs_pkg::pafs_mem_s mem,
   output logic fill_busy,
   output logic suspended_op_flag
);
   import pafs_pkg::*;

   typedef struct packed {
      pafs_aphase_s aph;
      logic rdy;
      logic [31:0] rdata;
      logic [12:0] ctrl;
      logic [31:0] dest;
      logic [31:0] extent;
      logic [31:0] pitch;
      logic [4:0] pixw;
      logic [31:0] wstart;
      logic [31:0] wend;
      logic [15:0] color;
      logic go;
      logic resume;
      logic done;
      logic susp;
      logic miss;
      logic busy;
      logic isync1;
      logic isync2;
      pafs_state_e st;
      logic [4:0] scnt;
      logic [4:0] setup_cost;
      logic [3:0] g;
      logic [15:0] nwords;
      logic [15:0] lrows;
      logic [15:0] rows;
      logic [19:0] row_cost;
      logic [19:0] rc;
      logic [15:0] wc;
      logic [3:0] gc;
      logic [2:0] tail;
      logic [1:0] cls;
      logic [1:0] kind;
      logic [31:0] row_base;
      logic [31:0] wa;
      pafs_mem_s mem;
      logic [31:0] cyc;
      logic [31:0] exp_total;
   } pafs_regs_s;

   localparam pafs_regs_s S_RST = '{ctrl: CTRL_RST, pixw: PIXW_RST, st: ST_IDLE, default: '0};

   pafs_regs_s s;
   pafs_regs_s n;

   // window clip and row shape terms
   logic [15:0] x0, y0, dx, dy;
   logic [16:0] x1, y1, cx0, cy0, cx1, cy1;
   logic clip_on, sadj, eadj, miss_c, rd_g, hold;
   logic [15:0] cdx, cdy, nw;
   logic [31:0] start_bit, span;
   logic [1:0] cls_c, kind_c, op;
   logic [3:0] g_c, adj_c;
   logic [2:0] k_c, c_c;
   logic [19:0] rcost_c;
   logic [4:0] su_c;

   // ==========================================================
   // next state
   always_comb begin
      n = s;
      n.mem.wr = 1'b0;
      n.mem.rmw = 1'b0;
      n.go = 1'b0;
      n.resume = 1'b0;
      n.rdy = 1'b1;
      hold = 1'b0;
      // two-stage synchroniser on the interrupt pin
      n.isync1 = int_req;
      n.isync2 = s.isync1;

      x0 = s.dest[15:0];
      y0 = s.dest[31:16];
      dx = s.extent[15:0];
      dy = s.extent[31:16];
      x1 = {1'b0, x0} + {1'b0, dx} - 17'd1;
      y1 = {1'b0, y0} + {1'b0, dy} - 17'd1;
      clip_on = s.ctrl[CB_XY] & (|s.ctrl[CB_WIN +: 2]);
      sadj = clip_on & ((x0 < s.wstart[15:0]) | (y0 < s.wstart[31:16]));
      eadj = clip_on & ((x1 > {1'b0, s.wend[15:0]}) | (y1 > {1'b0, s.wend[31:16]}));
      cx0 = (clip_on && x0 < s.wstart[15:0]) ? {1'b0, s.wstart[15:0]} : {1'b0, x0};
      cy0 = (clip_on && y0 < s.wstart[31:16]) ? {1'b0, s.wstart[31:16]} : {1'b0, y0};
      cx1 = (clip_on && x1 > {1'b0, s.wend[15:0]}) ? {1'b0, s.wend[15:0]} : x1;
      cy1 = (clip_on && y1 > {1'b0, s.wend[31:16]}) ? {1'b0, s.wend[31:16]} : y1;
      miss_c = (dx == 16'h0000) | (dy == 16'h0000) | (cx0 > cx1) | (cy0 > cy1);
      cdx = 16'(cx1 - cx0 + 17'd1);
      cdy = 16'(cy1 - cy0 + 17'd1);

      // word count from pointer, clipped X and pixel size
      start_bit = s.ctrl[CB_XY] ? 32'(32'(cy0[15:0]) * s.pitch + 32'(cx0[15:0]) * 32'(s.pixw)) : s.dest;
      span = 32'(start_bit[3:0]) + 32'(cdx) * 32'(s.pixw);
      nw = 16'((span + 32'd15) >> 4);
      // class from edge alignment: A, B lead ok, C trail ok, D neither
      // first row class kept for every row
      cls_c = {start_bit[3:0] != 4'h0, span[3:0] != 4'h0};
      kind_c = (nw == 16'd1) ? 2'd0 : ((nw == 16'd2) ? 2'd1 : 2'd2);

      op = s.ctrl[CB_OP +: 2];
      rd_g = s.ctrl[CB_PMASK] | s.ctrl[CB_TRANSP] | s.ctrl[CB_RMW];
      g_c = rd_g ? G_READ[op] : G_PLAIN[op];
      adj_c = 4'h0;
      if (s.ctrl[CB_PMASK] | s.ctrl[CB_TRANSP]) begin
         adj_c = (cls_c == 2'd3) ? ADJ_D : ((cls_c != 2'd0) ? ADJ_BC : 4'h0);
      end
      case (kind_c)
         2'd0: begin
            k_c = K_SHORT[cls_c];
            c_c = C_SHORT[cls_c];
         end
         2'd1: begin
            k_c = K_MED[cls_c];
            c_c = C_MED[cls_c];
         end
         default: begin
            k_c = K_LONG[cls_c];
            c_c = C_LONG[cls_c];
         end
      endcase
      rcost_c = 20'(k_c) + 20'(nw * 16'(g_c)) - 20'(adj_c);

      // setup cost; corner adjust bits not consulted
      if (!s.ctrl[CB_XY]) begin
         su_c = SU_LIN;
      end else if (!clip_on) begin
         su_c = SU_NOCLIP;
      end else if (miss_c) begin
         su_c = SU_FITS;
      end else if (sadj && eadj) begin
         su_c = SU_BOTH;
      end else if (sadj) begin
         su_c = SU_START;
      end else if (eadj) begin
         su_c = SU_DIMS;
      end else begin
         su_c = SU_FITS;
      end
      if (s.ctrl[CB_NOCACHE]) begin
         su_c = su_c + SU_NOCACHE;
      end

      // ==========================================================
      // bus slave: address phase capture and read data
      n.aph.act = hsel & hready & htrans[1] & (hsize == 3'b010);
      n.aph.wr = hwrite;
      n.aph.addr = haddr[7:0];
      n.rdata = 32'h0;
      if (hsel && hready && htrans[1] && !hwrite && hsize == 3'b010) begin
         case (haddr[7:0])
            OFF_CTRL: n.rdata = {19'h0, s.ctrl};
            OFF_DEST: n.rdata = s.dest;
            OFF_EXTENT: n.rdata = s.extent;
            OFF_PITCH: n.rdata = s.pitch;
            OFF_PIXW: n.rdata = {27'h0, s.pixw};
            OFF_WSTART: n.rdata = s.wstart;
            OFF_WEND: n.rdata = s.wend;
            OFF_COLOR: n.rdata = {16'h0, s.color};
            OFF_STATUS: n.rdata = {24'h0, s.kind, s.cls, s.miss, s.susp, s.done, s.busy};
            OFF_SHAPE: n.rdata = {s.lrows, s.nwords};
            OFF_CYCLES: n.rdata = s.cyc;
            default: n.rdata = 32'h0;
         endcase
      end
      // data phase writes; done and suspend status bits are write one to clear
      if (s.aph.act && s.aph.wr) begin
         case (s.aph.addr)
            OFF_CTRL: begin
               n.ctrl = hwdata[12:0];
               n.go = hwdata[CB_START];
               n.resume = hwdata[CB_RESUME];
            end
            OFF_DEST: n.dest = hwdata;
            OFF_EXTENT: n.extent = hwdata;
            OFF_PITCH: n.pitch = hwdata;
            OFF_PIXW: n.pixw = hwdata[4:0];
            OFF_WSTART: n.wstart = hwdata;
            OFF_WEND: n.wend = hwdata;
            OFF_COLOR: n.color = hwdata[15:0];
            OFF_STATUS: begin
               n.done = s.done & ~hwdata[SB_DONE];
               n.susp = s.susp & ~hwdata[SB_SUSP];
            end
            default: n.ctrl = s.ctrl;
         endcase
      end

      // ==========================================================
      // sequencer; flag sets below win over clears above
      case (s.st)
         ST_IDLE: begin
            if (s.go) begin
               n.st = ST_SETUP;
               n.done = 1'b0;
               n.cyc = 32'h0;
               n.scnt = su_c - 5'd1;
               n.setup_cost = su_c;
               n.miss = miss_c;
               n.g = g_c;
               n.nwords = nw;
               n.lrows = cdy;
               n.rows = cdy;
               n.row_cost = rcost_c;
               n.tail = c_c;
               n.cls = cls_c;
               n.kind = kind_c;
               n.row_base = start_bit;
               n.wa = {start_bit[31:4], 4'h0};
               n.mem.data = s.color;
               n.exp_total = 32'(su_c) + (miss_c ? 32'h0 : (32'(cdy) * 32'(rcost_c) + 32'(c_c)));
            end
         end
         ST_SETUP: begin
            // no write until clipping is done
            n.scnt = s.scnt - 5'd1;
            if (s.scnt == 5'd0) begin
               if (s.miss) begin
                  n.st = ST_IDLE;
                  n.done = 1'b1;
               end else begin
                  n.st = ST_ROW;
                  n.rc = s.row_cost - 20'd1;
                  n.wc = 16'h0;
                  n.gc = 4'h0;
               end
            end
         end
         ST_ROW: begin
            if (s.gc == 4'h0 && s.wc < s.nwords && s.isync2) begin
               n.st = ST_SUSP;
               n.susp = 1'b1;
               hold = 1'b1;
            end else begin
               if (s.gc == 4'h0 && s.wc < s.nwords) begin
                  // one whole word per step, rising X
                  n.mem.wr = 1'b1;
                  n.mem.addr = s.wa;
                  n.mem.rmw = (s.wc == 16'h0 && s.cls[1]) || (s.wc == s.nwords - 16'd1 && s.cls[0]);
                  n.wa = s.wa + 32'd16;
                  n.wc = s.wc + 16'd1;
                  n.gc = s.g - 4'd1;
               end else if (s.gc != 4'h0) begin
                  n.gc = s.gc - 4'd1;
               end
               n.rc = s.rc - 20'd1;
               if (s.rc == 20'd0) begin
                  n.rows = s.rows - 16'd1;
                  if (s.rows == 16'd1) begin
                     n.st = ST_TAIL;
                     n.scnt = 5'(s.tail) - 5'd1;
                  end else begin
                     n.rc = s.row_cost - 20'd1;
                     n.wc = 16'h0;
                     n.gc = 4'h0;
                     n.row_base = s.row_base + s.pitch;
                     n.wa = {n.row_base[31:4], 4'h0};
                     if (s.isync2) begin
                        n.st = ST_SUSP;
                        n.susp = 1'b1;
                     end
                  end
               end
            end
         end
         ST_TAIL: begin
            n.scnt = s.scnt - 5'd1;
            if (s.scnt == 5'd0) begin
               n.st = ST_IDLE;
               n.done = 1'b1;
            end
         end
         ST_SUSP: begin
            // context stays in place until software resumes
            if (s.resume) begin
               n.st = ST_ROW;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      // busy states counted one per clock, except suspend and a row state that enters it at a word boundary
      if (s.st != ST_IDLE && s.st != ST_SUSP && !hold) begin
         n.cyc = s.cyc + 32'd1;
      end
      n.busy = (n.st != ST_IDLE);
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= S_RST;
      end else begin
         s <= n;
      end
   end

   // outputs straight from state; hresp tied low
   assign hreadyout = s.rdy;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign mem = s.mem;
   assign fill_busy = s.busy;
   assign suspended_op_flag = s.susp;

   // ==========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_total;
      (s.st != ST_IDLE && n.st == ST_IDLE) |-> (s.cyc + 32'd1 == s.exp_total);
   endproperty
   a_total: assert property (p_total) else $error("fill length differs from setup plus transfer");

   property p_no_early_write;
      (s.st == ST_SETUP) |=> !s.mem.wr;
   endproperty
   a_no_early_write: assert property (p_no_early_write) else $error("word written during setup");

   property p_setup_lin;
      ($rose(s.st == ST_SETUP) && s.setup_cost == 5'd4) |-> (s.st == ST_SETUP) [*4] ##1 (s.st != ST_SETUP);
   endproperty
   a_setup_lin: assert property (p_setup_lin) else $error("linear setup not four states");

   property p_setup_both;
      (s.st == ST_IDLE && s.go && clip_on && sadj && eadj && !miss_c && !s.ctrl[CB_NOCACHE]) |=> s.setup_cost == 5'd20;
   endproperty
   a_setup_both: assert property (p_setup_both) else $error("both-corner setup not twenty");

   property p_nocache;
      (s.st == ST_IDLE && s.go && !s.ctrl[CB_XY] && s.ctrl[CB_NOCACHE]) |=> s.setup_cost == 5'd7;
   endproperty
   a_nocache: assert property (p_nocache) else $error("uncached linear setup not seven");

   property p_whole_word;
      s.mem.wr |-> (s.mem.addr[3:0] == 4'h0);
   endproperty
   a_whole_word: assert property (p_whole_word) else $error("write address not word aligned");

   property p_step;
      (s.mem.wr && s.st == ST_ROW && s.wc < s.nwords && s.g == 4'd2 && s.rc > 20'd2 && !s.isync1 && !s.isync2)
         |-> ##2 (s.mem.wr && s.mem.addr == $past(s.mem.addr, 2) + 32'd16);
   endproperty
   a_step: assert property (p_step) else $error("words not written in rising order");

   property p_g_plain;
      (s.st == ST_IDLE && s.go && !rd_g && op == 2'd3) |=> s.g == 4'd6;
   endproperty
   a_g_plain: assert property (p_g_plain) else $error("plain factor wrong");

   property p_g_read;
      (s.st == ST_IDLE && s.go && s.ctrl[CB_PMASK] && op == 2'd2) |=> s.g == 4'd7;
   endproperty
   a_g_read: assert property (p_g_read) else $error("read factor wrong");

   property p_suspend;
      (s.st == ST_ROW && s.isync2 && s.rows > 16'd1) |-> ##[0:20] (s.st == ST_SUSP && s.susp);
   endproperty
   a_suspend: assert property (p_suspend) else $error("interrupt not taken in time");

   c_suspend: cover property (s.st == ST_ROW ##1 s.st == ST_SUSP);
   c_done_xy: cover property (s.st == ST_TAIL && s.ctrl[CB_XY] ##1 s.done);
   c_class_d: cover property (s.st == ST_ROW && s.cls == 2'd3 && s.kind == 2'd2);

endmodule

/* File: pafs_mem_model.sv */
/*
 * Memory-side model for the fill sequencer: takes each word write,
 * keeps the stored pixels and counts writes and partial writes.
 * Assumes mem.wr is a one-cycle strobe sampled at the rising edge.
 */
`timescale 1ns/1ps
module pafs_mem_model (
   input wire logic hclk,
   input wire pafs_pkg::pafs_mem_s mem,
   input wire logic fill_busy
);
   import pafs_pkg::*;
   int n_wr = 0;
   int n_rmw = 0;
   int n_back = 0;
   logic armed = 1'b1;
   logic [31:0] first_addr = '0;
   logic [31:0] prev_addr = '0;
   logic [15:0] pix [int];
   // ==========================================================
   // word write port, one memory cycle per strobe
   // one cycle per word
   always @(posedge hclk) begin
      if (fill_busy !== 1'b1)
         armed = 1'b1;
      if (mem.wr === 1'b1) begin
         n_wr++;
         if (mem.rmw === 1'b1)
            n_rmw++;
         pix[int'(mem.addr[31:4])] = mem.data;
         if (armed)
            first_addr = mem.addr;
         else if (mem.addr <= prev_addr)
            n_back++;   // address did not rise
         armed = 1'b0;
         prev_addr = mem.addr;
      end
   end
endmodule

/* File: pafs_pkg.sv */
/*
 * Shared constants and types for the pixel array fill sequencer:
 * register offsets, control and status bit positions, reset values,
 * setup and per-word timing tables, sequencer states and carriers.
 * Assumes a 32-bit AHB-Lite bus with one register per aligned word.
 */
package pafs_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DEST = 8'h04;
   localparam logic [7:0] OFF_EXTENT = 8'h08;
   localparam logic [7:0] OFF_PITCH = 8'h0c;
   localparam logic [7:0] OFF_PIXW = 8'h10;
   localparam logic [7:0] OFF_WSTART = 8'h14;
   localparam logic [7:0] OFF_WEND = 8'h18;
   localparam logic [7:0] OFF_COLOR = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_SHAPE = 8'h24;
   localparam logic [7:0] OFF_CYCLES = 8'h28;

   // ==========================================================
   // control bit positions
   localparam int CB_START = 0;
   localparam int CB_RESUME = 1;
   localparam int CB_XY = 2;
   localparam int CB_WIN = 3;
   localparam int CB_OP = 5;
   localparam int CB_PMASK = 7;
   localparam int CB_TRANSP = 8;
   localparam int CB_RMW = 9;
   localparam int CB_NOCACHE = 10;
   localparam int CB_CAH = 11;
   localparam int CB_CAV = 12;

   // status bit positions
   localparam int SB_BUSY = 0;
   localparam int SB_DONE = 1;
   localparam int SB_SUSP = 2;
   localparam int SB_MISS = 3;

   // reset values
   localparam logic [12:0] CTRL_RST = 13'h0000;
   localparam logic [4:0] PIXW_RST = 5'h10;

   // ==========================================================
   // setup costs in machine states
   localparam logic [4:0] SU_LIN = 5'd4;
   localparam logic [4:0] SU_NOCLIP = 5'd6;
   localparam logic [4:0] SU_FITS = 5'd9;
   localparam logic [4:0] SU_START = 5'd16;
   localparam logic [4:0] SU_DIMS = 5'd12;
   localparam logic [4:0] SU_BOTH = 5'd20;
   localparam logic [4:0] SU_NOCACHE = 5'd3;

   // per-word cost G by pixel op group, plain and read-before-write
   localparam logic [3:0] G_PLAIN [4] = '{4'd2, 4'd4, 4'd5, 4'd6};
   localparam logic [3:0] G_READ [4] = '{4'd4, 4'd6, 4'd7, 4'd8};
   localparam logic [3:0] ADJ_BC = 4'd2;
   localparam logic [3:0] ADJ_D = 4'd4;

   // row overhead k and final term c, indexed by class A..D
   localparam logic [2:0] K_SHORT [4] = '{3'd1, 3'd2, 3'd2, 3'd2};
   localparam logic [2:0] C_SHORT [4] = '{3'd2, 3'd2, 3'd1, 3'd1};
   localparam logic [2:0] K_MED [4] = '{3'd2, 3'd3, 3'd3, 3'd4};
   localparam logic [2:0] C_MED [4] = '{3'd2, 3'd2, 3'd2, 3'd1};
   localparam logic [2:0] K_LONG [4] = '{3'd1, 3'd2, 3'd3, 3'd4};
   localparam logic [2:0] C_LONG [4] = '{3'd2, 3'd5, 3'd2, 3'd1};

   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_ROW = 3'b011,
      ST_TAIL = 3'b010,
      ST_SUSP = 3'b110
   } pafs_state_e;

   typedef struct packed {
      logic wr;
      logic rmw;
      logic [31:0] addr;
      logic [15:0] data;
   } pafs_mem_s;

   typedef struct packed {
      logic act;
      logic wr;
      logic [7:0] addr;
   } pafs_aphase_s;

endpackage

/* File: pixel_array_fill_sequencer_test.sv */
/*
 * Self-checking bench for the fill sequencer: AHB-Lite register access,
 * setup and transfer state counts, word order, suspend and resume.
 * Assumes zero-wait slave answers and the memory model beside it.
 */
`timescale 1ns/1ps
module pixel_array_fill_sequencer_test;
   import pafs_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic int_req = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   pafs_mem_s mem;
   logic fill_busy;
   logic suspended_op_flag;
   logic rdy_n;
   logic [31:0] rd_n;
   logic [31:0] r;
   int num_errors = 0;
   int n_checks = 0;

   // ==========================================================
   // clock, design and memory model
   always #2 hclk = ~hclk;
   pafs_fill pafs_fill_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .int_req(int_req), .mem(mem), .fill_busy(fill_busy),
      .suspended_op_flag(suspended_op_flag));
   pafs_mem_model pafs_mem_model_inst (.hclk(hclk), .mem(mem), .fill_busy(fill_busy));
   // bus answer as seen just before each rising edge
   always @(negedge hclk) begin
      rdy_n = hreadyout;
      rd_n = hrdata;
   end

   // ==========================================================
   // shared tasks
   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   // one single word transfer, address then data phase
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (rdy_n !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (rdy_n !== 1'b1);
      q = rd_n;
   endtask
   // program, start, and count busy and setup states
   task automatic run(logic [12:0] c, logic [31:0] d, e, pw, ws, we, int su, tot, nw, nr, logic [31:0] a0);
      int b;
      int s;
      int w0;
      int r0;
      logic seen;
      w0 = pafs_mem_model_inst.n_wr;
      r0 = pafs_mem_model_inst.n_rmw;
      b = 0;
      s = 0;
      seen = 1'b0;
      bus(1'b1, OFF_DEST, d, r);
      bus(1'b1, OFF_EXTENT, e, r);
      bus(1'b1, OFF_PITCH, 32'h00000100, r);
      bus(1'b1, OFF_PIXW, pw, r);
      bus(1'b1, OFF_WSTART, ws, r);
      bus(1'b1, OFF_WEND, we, r);
      bus(1'b1, OFF_COLOR, 32'h0000a5c3, r);
      bus(1'b1, OFF_CTRL, {19'h0, c} | 32'h1, r);
      for (int i = 0; i < 3000 && !(b > 0 && fill_busy !== 1'b1); i++) begin
         @(posedge hclk);
         #1;
         if (fill_busy === 1'b1) begin
            b++;
            if (mem.wr === 1'b1)
               seen = 1'b1;
            else if (!seen)
               s++;
         end
      end
      if (su >= 0) chk("setup", su + 1, s);
      if (tot >= 0) chk("busy", tot, b);
      bus(1'b0, OFF_CYCLES, 32'h0, r);
      if (tot >= 0) chk("cycles", tot, r);
      if (nw >= 0) chk("words", nw, pafs_mem_model_inst.n_wr - w0);
      if (nr >= 0) chk("partial", nr, pafs_mem_model_inst.n_rmw - r0);
      if (a0 != '1) chk("first", a0, pafs_mem_model_inst.first_addr);
   endtask

   // ==========================================================
   // scenarios
   task automatic s_regs;
      bus(1'b0, OFF_PIXW, 32'h0, r);
      chk("pixw", 32'h10, r);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      bus(1'b1, 8'h3c, 32'hffffffff, r);
      bus(1'b0, 8'h3c, 32'h0, r);
      chk("unmapped", 32'h0, r);
   endtask
   // linear long A: 4 + 2*(1+4*2) + 2
   task automatic s_lin;
      run(13'h0, 32'h0, {16'd2, 16'd4}, 32'h10, 32'h0, 32'h0, 4, 24, 8, 0, 32'h0);
      bus(1'b0, OFF_STATUS, 32'h0, r);
      chk("status", 32'h82, {24'h0, r[7:0]});
      chk("pixel", 32'ha5c3, {16'h0, pafs_mem_model_inst.pix[1]});
   endtask
   // short A for every op group, plain then read-first; corner bits vary
   task automatic s_ops;
      int g [8] = '{2, 4, 5, 6, 4, 6, 7, 8};
      logic [12:0] c;
      for (int i = 0; i < 8; i++) begin
         c = {i[1], i[0], 2'b00, i[2], 1'b0, i[1:0], 5'h0};
         run(c, 32'h0, {16'd1, 16'd1}, 32'h10, 32'h0, 32'h0, 4, 4 + 1 + g[i] + 2, 1, -1, '1);
      end
   endtask
   // XY unclipped: D medium masked, C long transparent, B long plain
   task automatic s_xy;
      run(13'h04e4, {16'd1, 16'd2}, {16'd3, 16'd4}, 32'h4, 32'h0, 32'h0, 9, 58, 6, 6, 32'h100);
      run(13'h0104, {16'd0, 16'd2}, {16'd2, 16'd14}, 32'h4, 32'h0, 32'h0, 6, 42, 8, -1, '1);
      run(13'h0004, 32'h0, {16'd1, 16'd10}, 32'h4, 32'h0, 32'h0, 6, 19, 3, -1, '1);
   endtask
   // preclip: fits, start adjust, dimension adjust, both
   task automatic s_win;
      run(13'h000c, {16'd1, 16'd1}, {16'd2, 16'd2}, 32'h10, 32'h0, {16'd100, 16'd100}, 9, 23, 4, -1, '1);
      run(13'h000c, 32'h0, {16'd4, 16'd4}, 32'h10, {16'd1, 16'd1}, {16'd100, 16'd100}, 16, 39, 9, 0,
         32'h110);
      run(13'h000c, {16'd1, 16'd1}, {16'd200, 16'd200}, 32'h10, 32'h0, {16'd3, 16'd3}, 12, -1, -1, -1, '1);
      run(13'h000c, 32'h0, {16'd200, 16'd200}, 32'h10, {16'd1, 16'd1}, {16'd3, 16'd3}, 20, -1, -1, -1, '1);
   endtask
   // suspend mid-row, stay still, resume, totals unchanged
   task automatic s_irq;
      int n;
      int w0;
      w0 = pafs_mem_model_inst.n_wr;
      bus(1'b1, OFF_EXTENT, {16'd4, 16'd16}, r);
      bus(1'b1, OFF_DEST, 32'h0, r);
      bus(1'b1, OFF_CTRL, 32'h1, r);
      repeat (20) @(posedge hclk);
      int_req <= 1'b1;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (suspended_op_flag !== 1'b1 && n < 40);
      chk("latency", 1, n <= 22);
      int_req <= 1'b0;
      n = pafs_mem_model_inst.n_wr;
      repeat (8) @(posedge hclk);
      chk("held", n, pafs_mem_model_inst.n_wr);
      chk("busy held", 1, fill_busy);
      bus(1'b1, OFF_CTRL, 32'h2, r);
      n = 0;
      while (fill_busy === 1'b1 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      bus(1'b0, OFF_CYCLES, 32'h0, r);
      chk("cycles", 138, r);
      chk("words", 64, pafs_mem_model_inst.n_wr - w0);
      bus(1'b1, OFF_STATUS, 32'h4, r);
      @(posedge hclk);
      chk("flag", 0, suspended_op_flag);
      chk("order", 0, pafs_mem_model_inst.n_back);
   endtask

   // ==========================================================
   // verdict and main sequence
   task final_report;
      if (num_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #60000;
      num_errors++;
      final_report;
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      s_regs;
      s_lin;
      s_ops;
      s_xy;
      s_win;
      s_irq;
      final_report;
   end
endmodule
